// File: cbl_pkg.sv
package cbl_pkg;

  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned NUM_BANKS = 8;
  localparam int unsigned BANK_W = 3;
  localparam int unsigned ADDR_W = 13;
  localparam int unsigned TMR_W = 16;
  localparam int unsigned STATE_W = 4;

  // Times in ns; cycle counts are derived below.
  localparam int unsigned ACT_TO_ACT_SPACING_NS = 10;
  localparam int unsigned ROW_TO_COLUMN_DELAY_NS = 18;
  localparam int unsigned ROW_CLOSE_TIME_NS = 18;
  localparam int unsigned MODE_READ_BUSY_TIME_NS = 20;
  localparam int unsigned MODE_WRITE_BUSY_TIME_NS = 50;
  localparam int unsigned POWER_DOWN_EXIT_TIME_NS = 8;
  localparam int unsigned REFRESH_BUSY_TIME_NS = 130;
  localparam int unsigned INIT_BUSY_TIME_NS = 10000;
  localparam int unsigned BURST_TIME_NS = 40;

  // A least time rounds up to whole cycles, never below one.
  function automatic logic [TMR_W-1:0] ns_to_cyc(input int unsigned ns);
    int unsigned c;
    c = (ns * CLK_MHZ + 999) / 1000;
    if (c < 1) begin
      c = 1;
    end
    return TMR_W'(c);
  endfunction

  localparam logic [TMR_W-1:0] RRD_CYC = ns_to_cyc(ACT_TO_ACT_SPACING_NS);
  localparam logic [TMR_W-1:0] RCD_CYC = ns_to_cyc(ROW_TO_COLUMN_DELAY_NS);
  localparam logic [TMR_W-1:0] RP_CYC = ns_to_cyc(ROW_CLOSE_TIME_NS);
  localparam logic [TMR_W-1:0] MRD_CYC = ns_to_cyc(MODE_READ_BUSY_TIME_NS);
  localparam logic [TMR_W-1:0] MWR_CYC = ns_to_cyc(MODE_WRITE_BUSY_TIME_NS);
  localparam logic [TMR_W-1:0] XP_CYC = ns_to_cyc(POWER_DOWN_EXIT_TIME_NS);
  localparam logic [TMR_W-1:0] RFC_CYC = ns_to_cyc(REFRESH_BUSY_TIME_NS);
  localparam logic [TMR_W-1:0] INIT_CYC = ns_to_cyc(INIT_BUSY_TIME_NS);
  localparam logic [TMR_W-1:0] BURST_CYC = ns_to_cyc(BURST_TIME_NS);

  typedef enum logic [3:0] {
    CMD_NO_OPERATION = 4'h0,
    CMD_ACTIVATE = 4'h1,
    CMD_READ = 4'h2,
    CMD_WRITE = 4'h3,
    CMD_PRECHARGE = 4'h4,
    CMD_PRECHARGE_ALL = 4'h5,
    CMD_MODE_READ = 4'h6,
    CMD_MODE_WRITE = 4'h7,
    CMD_MODE_RESET = 4'h8,
    CMD_BURST_STOP = 4'h9,
    CMD_REFRESH = 4'ha
  } cbl_cmd_e;

  typedef enum logic [3:0] {
    BK_POWER_ON = 4'h0,
    BK_IDLE = 4'h1,
    BK_ACTIVATING = 4'h2,
    BK_ACTIVE = 4'h3,
    BK_PRECHARGING = 4'h4,
    BK_READING = 4'h5,
    BK_WRITING = 4'h6,
    BK_READ_AP = 4'h7,
    BK_WRITE_AP = 4'h8,
    BK_MODE_READ_IDLE = 4'h9,
    BK_MODE_READ_ACTIVE = 4'ha,
    BK_MODE_READ_RESET = 4'hb,
    BK_MODE_WRITING = 4'hc,
    BK_RESETTING = 4'hd,
    BK_REFRESHING = 4'he
  } cbl_bank_e;

  typedef struct packed {
    cbl_cmd_e cmd;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
    logic ap;
  } cbl_req_s;

  typedef struct packed {
    logic cke;
    logic cs_n;
    cbl_cmd_e cmd;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
    logic ap;
  } cbl_pin_s;

endpackage

// File: cbl_bank_track.sv
`timescale 1ns/100ps
module cbl_bank_track #(
  parameter logic [15:0] RCD_CYC = cbl_pkg::RCD_CYC,
  parameter logic [15:0] RP_CYC = cbl_pkg::RP_CYC,
  parameter logic [15:0] MRD_CYC = cbl_pkg::MRD_CYC,
  parameter logic [15:0] MWR_CYC = cbl_pkg::MWR_CYC,
  parameter logic [15:0] RFC_CYC = cbl_pkg::RFC_CYC,
  parameter logic [15:0] INIT_CYC = cbl_pkg::INIT_CYC,
  parameter logic [15:0] BURST_CYC = cbl_pkg::BURST_CYC
) (
  input wire logic i_clk_sys, // System clock.
  input wire logic i_arst_n, // Asynchronous reset, active low.
  input wire logic i_hit, // A command is issued to this bank this cycle.
  input wire cbl_pkg::cbl_cmd_e i_cmd, // Issued command.
  input wire logic i_ap, // Auto precharge with read or write.
  output cbl_pkg::cbl_bank_e o_state, // Tracked bank state.
  output logic o_in_burst // Data burst still running.
);

  logic [15:0] tmr_reg;

  function automatic cbl_pkg::cbl_bank_e next_state(input cbl_pkg::cbl_bank_e cur, input cbl_pkg::cbl_cmd_e cmd,
                                                    input logic ap);
    case (cmd)
      cbl_pkg::CMD_ACTIVATE: next_state = cbl_pkg::BK_ACTIVATING;
      cbl_pkg::CMD_READ: next_state = ap ? cbl_pkg::BK_READ_AP : cbl_pkg::BK_READING;
      cbl_pkg::CMD_WRITE: next_state = ap ? cbl_pkg::BK_WRITE_AP : cbl_pkg::BK_WRITING;
      cbl_pkg::CMD_PRECHARGE: next_state = cbl_pkg::BK_PRECHARGING;
      cbl_pkg::CMD_PRECHARGE_ALL: next_state = cbl_pkg::BK_PRECHARGING;
      cbl_pkg::CMD_MODE_WRITE: next_state = cbl_pkg::BK_MODE_WRITING;
      cbl_pkg::CMD_MODE_RESET: next_state = cbl_pkg::BK_RESETTING;
      cbl_pkg::CMD_REFRESH: next_state = cbl_pkg::BK_REFRESHING;
      cbl_pkg::CMD_BURST_STOP: next_state = cbl_pkg::BK_ACTIVE;
      cbl_pkg::CMD_MODE_READ: begin
        if (cur == cbl_pkg::BK_RESETTING) begin
          next_state = cbl_pkg::BK_MODE_READ_RESET;
        end else if (cur == cbl_pkg::BK_ACTIVE || cur == cbl_pkg::BK_ACTIVATING) begin
          next_state = cbl_pkg::BK_MODE_READ_ACTIVE;
        end else begin
          next_state = cbl_pkg::BK_MODE_READ_IDLE;
        end
      end
      default: next_state = cur;
    endcase
  endfunction

  function automatic logic [15:0] busy_time(input cbl_pkg::cbl_bank_e st);
    case (st)
      cbl_pkg::BK_ACTIVATING: busy_time = RCD_CYC;
      cbl_pkg::BK_PRECHARGING: busy_time = RP_CYC;
      cbl_pkg::BK_READING, cbl_pkg::BK_WRITING, cbl_pkg::BK_READ_AP, cbl_pkg::BK_WRITE_AP: busy_time = BURST_CYC;
      cbl_pkg::BK_MODE_READ_IDLE, cbl_pkg::BK_MODE_READ_ACTIVE, cbl_pkg::BK_MODE_READ_RESET: busy_time = MRD_CYC;
      cbl_pkg::BK_MODE_WRITING: busy_time = MWR_CYC;
      cbl_pkg::BK_RESETTING: busy_time = INIT_CYC;
      cbl_pkg::BK_REFRESHING: busy_time = RFC_CYC;
      default: busy_time = 16'h0000;
    endcase
  endfunction

  // One state register per bank, moved only by an issued command or its timer.
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_state <= cbl_pkg::BK_POWER_ON;
      tmr_reg <= 16'h0000;
      o_in_burst <= 1'b0;
    end else if (i_hit && i_cmd != cbl_pkg::CMD_NO_OPERATION) begin
      o_state <= next_state(o_state, i_cmd, i_ap);
      tmr_reg <= busy_time(next_state(o_state, i_cmd, i_ap));
      o_in_burst <= (i_cmd == cbl_pkg::CMD_READ || i_cmd == cbl_pkg::CMD_WRITE);
    end else if (tmr_reg > 16'h0001) begin
      tmr_reg <= tmr_reg - 16'h0001;
    end else if (tmr_reg == 16'h0001) begin
      if (o_in_burst && (o_state == cbl_pkg::BK_READ_AP || o_state == cbl_pkg::BK_WRITE_AP)) begin
        // The auto precharge runs after the burst.
        tmr_reg <= RP_CYC;
      end else begin
        tmr_reg <= 16'h0000;
        case (o_state)
          cbl_pkg::BK_ACTIVATING, cbl_pkg::BK_READING, cbl_pkg::BK_WRITING,
          cbl_pkg::BK_MODE_READ_ACTIVE: o_state <= cbl_pkg::BK_ACTIVE;
          default: o_state <= cbl_pkg::BK_IDLE;
        endcase
      end
      o_in_burst <= 1'b0;
    end
  end

endmodule

// File: cbl_ctrl.sv
`timescale 1ns/100ps
// Functional notes
// - With the reference bank idle, any command the target bank supports is sent.
// - Keep the activate-to-activate spacing between activates to different banks.
// - Precharge one or all banks; all-bank form needs every bank precharge-ready.
// - Burst stop only during a running burst; the bank returns to active.
// - Burst stop goes only to the bank whose burst is running.
// - Write after read only once the read burst has ended.
// - Read after write only once the write burst has ended.
// - Other banks stay usable while an auto precharge burst runs.
// - Refresh and mode write only when every bank is idle.
// - Only no-operation commands while a mode read or write is busy.
// - Mode reset with every bank idle or power-on enters resetting.
// - Commands only with clock enable high now and before, after exit time.
// - Anything outside the allowed set is refused and never sent.
module cbl_ctrl #(
  parameter int unsigned NUM_BANKS = cbl_pkg::NUM_BANKS,
  parameter logic [15:0] RRD_CYC = cbl_pkg::RRD_CYC,
  parameter logic [15:0] XP_CYC = cbl_pkg::XP_CYC,
  parameter logic [15:0] INIT_CYC = cbl_pkg::INIT_CYC,
  parameter logic [15:0] BURST_CYC = cbl_pkg::BURST_CYC
) (
  input wire logic i_clk_sys, // System clock, 100 MHz.
  input wire logic i_arst_n, // Asynchronous reset, active low.
  input wire logic i_req_valid, // Command request present.
  input wire cbl_pkg::cbl_req_s i_req, // Requested command, bank and address.
  output logic o_req_ready, // Requests are being taken.
  output logic o_req_ack, // Request was sent to the pins.
  output logic o_req_refused, // Request was illegal now and dropped.
  output cbl_pkg::cbl_pin_s o_pin, // Command pins toward the memory.
  output logic [4*NUM_BANKS-1:0] o_bank_state // Tracked state of each bank.
);

  generate
    if (NUM_BANKS < 1 || NUM_BANKS > (1 << cbl_pkg::BANK_W) || RRD_CYC == 16'h0000 || BURST_CYC == 16'h0000 ||
        INIT_CYC == 16'h0000) begin : g_bad_param
      $error("cbl_ctrl parameter out of range");
    end
  endgenerate

  cbl_pkg::cbl_bank_e st [NUM_BANKS];
  logic [NUM_BANKS-1:0] in_burst;
  logic [NUM_BANKS-1:0] hit;
  logic cke_prev_reg;
  logic [15:0] xp_cnt_reg;
  logic [15:0] rrd_cnt_reg;
  logic [cbl_pkg::BANK_W-1:0] last_burst_bank_reg;
  logic legal;
  logic issue;
  logic all_idle;
  logic all_start;
  logic all_pre_ok;
  logic mode_busy;
  logic rd_burst;
  logic wr_burst;
  cbl_pkg::cbl_bank_e tgt;

  function automatic logic pre_ok(input cbl_pkg::cbl_bank_e s);
    return s == cbl_pkg::BK_IDLE || s == cbl_pkg::BK_ACTIVE;
  endfunction

  function automatic logic is_broadcast(input cbl_pkg::cbl_cmd_e c);
    return c == cbl_pkg::CMD_PRECHARGE_ALL || c == cbl_pkg::CMD_MODE_WRITE || c == cbl_pkg::CMD_MODE_RESET ||
           c == cbl_pkg::CMD_REFRESH;
  endfunction

  always_comb begin
    all_idle = 1'b1;
    all_start = 1'b1;
    all_pre_ok = 1'b1;
    mode_busy = 1'b0;
    rd_burst = 1'b0;
    wr_burst = 1'b0;
    for (int b = 0; b < NUM_BANKS; b++) begin
      all_idle &= (st[b] == cbl_pkg::BK_IDLE);
      all_start &= (st[b] == cbl_pkg::BK_IDLE || st[b] == cbl_pkg::BK_POWER_ON);
      all_pre_ok &= pre_ok(st[b]);
      mode_busy |= (st[b] == cbl_pkg::BK_MODE_READ_IDLE || st[b] == cbl_pkg::BK_MODE_READ_ACTIVE ||
                    st[b] == cbl_pkg::BK_MODE_READ_RESET || st[b] == cbl_pkg::BK_MODE_WRITING ||
                    st[b] == cbl_pkg::BK_REFRESHING);
      rd_burst |= in_burst[b] && (st[b] == cbl_pkg::BK_READING || st[b] == cbl_pkg::BK_READ_AP);
      wr_burst |= in_burst[b] && (st[b] == cbl_pkg::BK_WRITING || st[b] == cbl_pkg::BK_WRITE_AP);
    end
  end

  assign tgt = (32'(i_req.bank) < NUM_BANKS) ? st[i_req.bank] : cbl_pkg::BK_POWER_ON;

  // Legality of the request against the tracked states of all banks.
  always_comb begin
    legal = 1'b0;
    case (i_req.cmd)
      cbl_pkg::CMD_NO_OPERATION: legal = 1'b1;
      cbl_pkg::CMD_ACTIVATE: legal = (tgt == cbl_pkg::BK_IDLE) && (rrd_cnt_reg == 16'h0000);
      cbl_pkg::CMD_READ: legal = (tgt == cbl_pkg::BK_ACTIVE || tgt == cbl_pkg::BK_READING) && !wr_burst;
      cbl_pkg::CMD_WRITE: legal = (tgt == cbl_pkg::BK_ACTIVE || tgt == cbl_pkg::BK_WRITING) && !rd_burst;
      cbl_pkg::CMD_PRECHARGE: legal = pre_ok(tgt);
      cbl_pkg::CMD_PRECHARGE_ALL: legal = all_pre_ok;
      cbl_pkg::CMD_MODE_READ: begin
        legal = tgt == cbl_pkg::BK_IDLE || tgt == cbl_pkg::BK_ACTIVATING || tgt == cbl_pkg::BK_PRECHARGING ||
                tgt == cbl_pkg::BK_ACTIVE || tgt == cbl_pkg::BK_RESETTING;
      end
      cbl_pkg::CMD_MODE_WRITE: legal = all_idle;
      cbl_pkg::CMD_REFRESH: legal = all_idle;
      cbl_pkg::CMD_MODE_RESET: legal = all_start;
      cbl_pkg::CMD_BURST_STOP: begin
        legal = (i_req.bank == last_burst_bank_reg) && in_burst[i_req.bank] &&
                (tgt == cbl_pkg::BK_READING || tgt == cbl_pkg::BK_WRITING);
      end
      default: legal = 1'b0;
    endcase
    if (i_req.cmd != cbl_pkg::CMD_NO_OPERATION) begin
      if (mode_busy || !o_pin.cke || !cke_prev_reg || xp_cnt_reg != 16'h0000) begin
        legal = 1'b0;
      end
      if (32'(i_req.bank) >= NUM_BANKS) begin
        legal = 1'b0;
      end
    end
  end

  assign issue = i_req_valid && o_req_ready && legal;

  genvar g;
  generate
    for (g = 0; g < NUM_BANKS; g++) begin : g_bank
      assign hit[g] = issue && (is_broadcast(i_req.cmd) || 32'(i_req.bank) == g);
      assign o_bank_state[4*g +: 4] = st[g];
      cbl_bank_track #(
        .INIT_CYC(INIT_CYC),
        .BURST_CYC(BURST_CYC)
      ) u_track (
        .i_clk_sys(i_clk_sys),
        .i_arst_n(i_arst_n),
        .i_hit(hit[g]),
        .i_cmd(i_req.cmd),
        .i_ap(i_req.ap),
        .o_state(st[g]),
        .o_in_burst(in_burst[g])
      );
    end
  endgenerate

  // Clock enable rises after reset and the exit time runs before any command.
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cke_prev_reg <= 1'b0;
      xp_cnt_reg <= XP_CYC;
    end else begin
      cke_prev_reg <= o_pin.cke;
      if (o_pin.cke && xp_cnt_reg != 16'h0000) begin
        xp_cnt_reg <= xp_cnt_reg - 16'h0001;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rrd_cnt_reg <= 16'h0000;
    end else if (issue && i_req.cmd == cbl_pkg::CMD_ACTIVATE) begin
      rrd_cnt_reg <= RRD_CYC - 16'h0001;
    end else if (rrd_cnt_reg != 16'h0000) begin
      rrd_cnt_reg <= rrd_cnt_reg - 16'h0001;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      last_burst_bank_reg <= '0;
    end else if (issue && (i_req.cmd == cbl_pkg::CMD_READ || i_req.cmd == cbl_pkg::CMD_WRITE)) begin
      last_burst_bank_reg <= i_req.bank;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pin <= '{cke: 1'b0, cs_n: 1'b1, cmd: cbl_pkg::CMD_NO_OPERATION, bank: '0, addr: '0, ap: 1'b0};
      o_req_ready <= 1'b0;
      o_req_ack <= 1'b0;
      o_req_refused <= 1'b0;
    end else begin
      o_pin.cke <= 1'b1;
      o_req_ready <= o_pin.cke && cke_prev_reg && (xp_cnt_reg == 16'h0000);
      o_req_ack <= issue;
      o_req_refused <= i_req_valid && o_req_ready && !legal;
      if (issue && i_req.cmd != cbl_pkg::CMD_NO_OPERATION) begin
        o_pin.cs_n <= 1'b0;
        o_pin.cmd <= i_req.cmd;
        o_pin.bank <= i_req.bank;
        o_pin.addr <= i_req.addr;
        o_pin.ap <= i_req.ap;
      end else begin
        o_pin.cs_n <= 1'b1;
        o_pin.cmd <= cbl_pkg::CMD_NO_OPERATION;
      end
    end
  end

  logic [15:0] act_gap_reg;
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      act_gap_reg <= 16'hffff;
    end else if (o_pin.cmd == cbl_pkg::CMD_ACTIVATE) begin
      act_gap_reg <= 16'h0001;
    end else if (act_gap_reg != 16'hffff) begin
      act_gap_reg <= act_gap_reg + 16'h0001;
    end
  end

  a_act_spacing_held: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    o_pin.cmd == cbl_pkg::CMD_ACTIVATE |-> act_gap_reg >= RRD_CYC) else $error("activates too close");
  a_stop_right_bank: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    o_pin.cmd == cbl_pkg::CMD_BURST_STOP |-> o_pin.bank == $past(last_burst_bank_reg)) else $error("stop to wrong bank");
  a_stop_in_burst: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    o_pin.cmd == cbl_pkg::CMD_BURST_STOP |-> st[o_pin.bank] == cbl_pkg::BK_ACTIVE && $past(in_burst[i_req.bank]))
    else $error("stop without burst");
  a_write_after_read: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    o_pin.cmd == cbl_pkg::CMD_WRITE |-> !$past(rd_burst)) else $error("write during read burst");
  a_read_after_write: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    o_pin.cmd == cbl_pkg::CMD_READ |-> !$past(wr_burst)) else $error("read during write burst");
  a_all_idle_cmds: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    o_pin.cmd == cbl_pkg::CMD_MODE_WRITE || o_pin.cmd == cbl_pkg::CMD_REFRESH |-> $past(all_idle))
    else $error("refresh or mode write with bank open");
  a_mode_busy_quiet: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    $past(mode_busy) |-> o_pin.cs_n && o_pin.cmd == cbl_pkg::CMD_NO_OPERATION) else $error("command in mode busy");
  a_clock_enable_ok: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    !o_pin.cs_n |-> $past(o_pin.cke) && $past(cke_prev_reg) && $past(xp_cnt_reg) == 16'h0000)
    else $error("command before exit time");
  a_prea_valid: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    o_pin.cmd == cbl_pkg::CMD_PRECHARGE_ALL |-> $past(all_pre_ok) ##1 !mode_busy) else $error("bad precharge all");
  a_reset_entry: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    o_pin.cmd == cbl_pkg::CMD_MODE_RESET |-> $past(all_start) && st[0] == cbl_pkg::BK_RESETTING)
    else $error("reset entry wrong");
  a_accept_sends: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    i_req_valid && o_req_ready && legal && i_req.cmd != cbl_pkg::CMD_NO_OPERATION |=> !o_pin.cs_n && o_req_ack)
    else $error("legal request not sent");

endmodule

// File: cbl_dev_model.sv
`timescale 1ns/100ps
module cbl_dev_model (
  input wire logic i_clk_sys, // System clock.
  input wire logic i_arst_n, // Asynchronous reset, active low.
  input wire cbl_pkg::cbl_pin_s i_pin, // Command pins from the controller.
  output logic [7:0] o_viol // Count of illegal commands seen.
);
  logic [7:0] open_reg;
  int busy;
  int gap;

  // Selects without a command, and commands failing the open-bank, busy, spacing or known-code checks, bump the count.
  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      open_reg = 8'h00;
      busy = 0;
      gap = 99;
      o_viol = 8'h00;
    end else begin
      gap++;
      if (busy > 0) begin
        busy--;
      end
      if (i_pin.cke && (!i_pin.cs_n != (i_pin.cmd != cbl_pkg::CMD_NO_OPERATION))) begin
        o_viol++;
      end
      if (i_pin.cke && !i_pin.cs_n) begin
        if (busy > 0) begin
          o_viol++;
        end
        case (i_pin.cmd)
          cbl_pkg::CMD_ACTIVATE: begin
            if (open_reg[i_pin.bank] || gap < int'(cbl_pkg::RRD_CYC)) begin
              o_viol++;
            end
            open_reg[i_pin.bank] = 1'b1;
            gap = 0;
          end
          cbl_pkg::CMD_READ, cbl_pkg::CMD_WRITE: begin
            if (!open_reg[i_pin.bank]) begin
              o_viol++;
            end
            if (i_pin.ap) begin
              open_reg[i_pin.bank] = 1'b0;
            end
          end
          cbl_pkg::CMD_BURST_STOP: begin
            if (!open_reg[i_pin.bank]) begin
              o_viol++;
            end
          end
          cbl_pkg::CMD_PRECHARGE: open_reg[i_pin.bank] = 1'b0;
          cbl_pkg::CMD_PRECHARGE_ALL: open_reg = 8'h00;
          cbl_pkg::CMD_MODE_READ: busy = int'(cbl_pkg::MRD_CYC);
          cbl_pkg::CMD_MODE_WRITE, cbl_pkg::CMD_REFRESH: begin
            if (open_reg != 8'h00) begin
              o_viol++;
            end
            busy = int'(cbl_pkg::MWR_CYC);
          end
          cbl_pkg::CMD_MODE_RESET: open_reg = 8'h00;
          default: o_viol++;
        endcase
      end
    end
  end
endmodule

// File: cross_bank_command_legality_bench.sv
`timescale 1ns/100ps
module cross_bank_command_legality_bench;
  localparam int INIT = 6;
  localparam int BURST = 8;
  localparam int RCD = int'(cbl_pkg::RCD_CYC);
  localparam int RP = int'(cbl_pkg::RP_CYC);
  localparam int MRD = int'(cbl_pkg::MRD_CYC);
  logic i_clk_sys = 1'b0;
  logic i_arst_n = 1'b0;
  logic i_req_valid = 1'b0;
  cbl_pkg::cbl_req_s i_req = '0;
  logic o_req_ready;
  logic o_req_ack;
  logic o_req_refused;
  cbl_pkg::cbl_pin_s o_pin;
  logic [31:0] o_bank_state;
  logic [7:0] viol;
  int mismatches = 0;
  int checked = 0;
  int seed = 69;
  cbl_pkg::cbl_bank_e st[8];
  cbl_pkg::cbl_bank_e nx[8];
  int tm[8];
  int lrw = 0;
  bit ok;
  logic pend = 1'b0;
  logic e_ok;
  cbl_pkg::cbl_req_s e_req;
  cbl_pkg::cbl_bank_e e_st;
  cbl_pkg::cbl_cmd_e rc[4] = '{cbl_pkg::CMD_ACTIVATE, cbl_pkg::CMD_PRECHARGE, cbl_pkg::CMD_READ, cbl_pkg::CMD_WRITE};

  cbl_ctrl #(.INIT_CYC(16'(INIT)), .BURST_CYC(16'(BURST))) i_cbl_ctrl (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
    .i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(o_req_ready), .o_req_ack(o_req_ack),
    .o_req_refused(o_req_refused), .o_pin(o_pin), .o_bank_state(o_bank_state));
  cbl_dev_model i_cbl_dev_model (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_pin(o_pin), .o_viol(viol));

  initial begin
    forever #5 i_clk_sys = ~i_clk_sys;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %0h, expected %0h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic put(input int b, input cbl_pkg::cbl_bank_e s, input int t, input cbl_pkg::cbl_bank_e n);
    st[b] = s;
    tm[b] = t;
    nx[b] = n;
  endtask

  task automatic put_all(input cbl_pkg::cbl_bank_e s, input int t);
    for (int b = 0; b < 8; b++) begin
      put(b, s, t, cbl_pkg::BK_IDLE);
    end
  endtask

  // Legality judged from the model's own bank states, never from the design.
  function automatic bit legal(input cbl_pkg::cbl_req_s r);
    bit rb, wb, busy, all_idle, all_on, pre_ok;
    cbl_pkg::cbl_bank_e s;
    {rb, wb, busy} = 3'h0;
    {all_idle, all_on, pre_ok} = 3'h7;
    for (int b = 0; b < 8; b++) begin
      rb |= st[b] == cbl_pkg::BK_READING || (st[b] == cbl_pkg::BK_READ_AP && tm[b] > RP);
      wb |= st[b] == cbl_pkg::BK_WRITING || (st[b] == cbl_pkg::BK_WRITE_AP && tm[b] > RP);
      busy |= st[b] inside {[cbl_pkg::BK_MODE_READ_IDLE:cbl_pkg::BK_MODE_WRITING], cbl_pkg::BK_REFRESHING};
      all_idle &= st[b] == cbl_pkg::BK_IDLE;
      all_on &= st[b] == cbl_pkg::BK_POWER_ON;
      pre_ok &= st[b] inside {cbl_pkg::BK_IDLE, cbl_pkg::BK_ACTIVE};
    end
    s = st[r.bank];
    if (r.cmd == cbl_pkg::CMD_NO_OPERATION) return 1'b1;
    if (busy) return 1'b0;
    case (r.cmd)
      cbl_pkg::CMD_ACTIVATE: return s == cbl_pkg::BK_IDLE;
      cbl_pkg::CMD_READ: return s inside {cbl_pkg::BK_ACTIVE, cbl_pkg::BK_READING} && !wb;
      cbl_pkg::CMD_WRITE: return s inside {cbl_pkg::BK_ACTIVE, cbl_pkg::BK_WRITING} && !rb;
      cbl_pkg::CMD_PRECHARGE: return s inside {cbl_pkg::BK_IDLE, cbl_pkg::BK_ACTIVE};
      cbl_pkg::CMD_PRECHARGE_ALL: return pre_ok;
      cbl_pkg::CMD_MODE_READ: return s inside {[cbl_pkg::BK_IDLE:cbl_pkg::BK_PRECHARGING], cbl_pkg::BK_RESETTING};
      cbl_pkg::CMD_MODE_WRITE, cbl_pkg::CMD_REFRESH: return all_idle;
      cbl_pkg::CMD_MODE_RESET: return all_idle || all_on;
      cbl_pkg::CMD_BURST_STOP: return int'(r.bank) == lrw && s inside {cbl_pkg::BK_READING, cbl_pkg::BK_WRITING};
      default: return 1'b0;
    endcase
  endfunction

  task automatic apply(input cbl_pkg::cbl_req_s r);
    int b;
    cbl_pkg::cbl_bank_e s;
    b = int'(r.bank);
    s = st[b];
    case (r.cmd)
      cbl_pkg::CMD_ACTIVATE: put(b, cbl_pkg::BK_ACTIVATING, RCD, cbl_pkg::BK_ACTIVE);
      cbl_pkg::CMD_READ: put(b, r.ap ? cbl_pkg::BK_READ_AP : cbl_pkg::BK_READING, r.ap ? BURST + RP : BURST,
        r.ap ? cbl_pkg::BK_IDLE : cbl_pkg::BK_ACTIVE);
      cbl_pkg::CMD_WRITE: put(b, r.ap ? cbl_pkg::BK_WRITE_AP : cbl_pkg::BK_WRITING, r.ap ? BURST + RP : BURST,
        r.ap ? cbl_pkg::BK_IDLE : cbl_pkg::BK_ACTIVE);
      cbl_pkg::CMD_PRECHARGE: put(b, cbl_pkg::BK_PRECHARGING, RP, cbl_pkg::BK_IDLE);
      cbl_pkg::CMD_PRECHARGE_ALL: put_all(cbl_pkg::BK_PRECHARGING, RP);
      cbl_pkg::CMD_MODE_READ: begin
        if (s == cbl_pkg::BK_RESETTING) begin
          put(b, cbl_pkg::BK_MODE_READ_RESET, MRD, cbl_pkg::BK_IDLE);
        end else if (s inside {cbl_pkg::BK_IDLE, cbl_pkg::BK_PRECHARGING}) begin
          put(b, cbl_pkg::BK_MODE_READ_IDLE, MRD, cbl_pkg::BK_IDLE);
        end else begin
          put(b, cbl_pkg::BK_MODE_READ_ACTIVE, MRD, cbl_pkg::BK_ACTIVE);
        end
      end
      cbl_pkg::CMD_MODE_WRITE: put_all(cbl_pkg::BK_MODE_WRITING, int'(cbl_pkg::MWR_CYC));
      cbl_pkg::CMD_MODE_RESET: put_all(cbl_pkg::BK_RESETTING, INIT);
      cbl_pkg::CMD_REFRESH: put_all(cbl_pkg::BK_REFRESHING, int'(cbl_pkg::RFC_CYC));
      cbl_pkg::CMD_BURST_STOP: put(b, cbl_pkg::BK_ACTIVE, 0, cbl_pkg::BK_ACTIVE);
      default: ;
    endcase
    if (r.cmd inside {cbl_pkg::CMD_READ, cbl_pkg::CMD_WRITE}) lrw = b;
  endtask

  always @(posedge i_clk_sys) begin
    if (pend) begin
      check(32'(o_req_ack), 32'(e_ok));
      check(32'(o_req_refused), 32'(!e_ok));
      check(32'(o_pin.cs_n), 32'(!e_ok || e_req.cmd == cbl_pkg::CMD_NO_OPERATION));
      check(32'(o_pin.cke), 32'h1);
      check(32'(o_pin.cmd), e_ok ? 32'(e_req.cmd) : 32'h0);
      check(32'(o_bank_state[4*e_req.bank+:4]), 32'(e_st));
      if (e_ok && e_req.cmd != cbl_pkg::CMD_NO_OPERATION) begin
        check(32'({o_pin.bank, o_pin.addr, o_pin.ap}), 32'({e_req.bank, e_req.addr, e_req.ap}));
      end
      check(32'(o_req_ready), 32'h1);
    end
    // Legality sees the bank states that stand before this edge, as the design does.
    ok = legal(i_req);
    for (int b = 0; b < 8; b++) begin
      if (tm[b] > 0) begin
        tm[b]--;
        if (tm[b] == 0) st[b] = nx[b];
      end
    end
    pend <= i_arst_n && i_req_valid && o_req_ready;
    if (i_arst_n && i_req_valid && o_req_ready) begin
      if (ok) apply(i_req);
      e_ok <= ok;
      e_req <= i_req;
      e_st <= st[i_req.bank];
    end
  end

  task automatic issue(input cbl_pkg::cbl_cmd_e c, input int b, input logic ap);
    int n;
    i_req_valid <= 1'b1;
    i_req <= '{cmd: c, bank: 3'(b), addr: 13'($random(seed)), ap: ap};
    n = 0;
    @(posedge i_clk_sys);
    while (o_req_ready !== 1'b1 && n < 50) begin
      n++;
      @(posedge i_clk_sys);
    end
    if (n >= 50) begin
      mismatches++;
      report_and_stop();
    end
  endtask

  task automatic idle(input int n);
    i_req_valid <= 1'b0;
    repeat (n) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    for (int b = 0; b < 8; b++) check(32'(o_bank_state[4*b+:4]), 32'(st[b]));
    @(posedge i_clk_sys);
  endtask

  initial begin
    put_all(cbl_pkg::BK_POWER_ON, 0);
    repeat (12) @(posedge i_clk_sys);
    i_arst_n <= 1'b1;
    idle(4);
    issue(cbl_pkg::CMD_ACTIVATE, 0, 1'b0);
    issue(cbl_pkg::CMD_MODE_RESET, 0, 1'b0);
    issue(cbl_pkg::CMD_MODE_READ, 0, 1'b0);
    idle(20);
    issue(cbl_pkg::CMD_ACTIVATE, 2, 1'b0);
    issue(cbl_pkg::CMD_ACTIVATE, 3, 1'b0);
    issue(cbl_pkg::CMD_NO_OPERATION, 5, 1'b0);
    idle(10);
    issue(cbl_pkg::CMD_MODE_READ, 2, 1'b0);
    idle(10);
    issue(cbl_pkg::CMD_READ, 2, 1'b0);
    issue(cbl_pkg::CMD_WRITE, 3, 1'b0);
    issue(cbl_pkg::CMD_BURST_STOP, 3, 1'b0);
    issue(cbl_pkg::CMD_BURST_STOP, 2, 1'b0);
    issue(cbl_pkg::CMD_WRITE, 3, 1'b0);
    issue(cbl_pkg::CMD_READ, 2, 1'b0);
    issue(cbl_pkg::CMD_BURST_STOP, 3, 1'b0);
    issue(cbl_pkg::CMD_READ, 2, 1'b1);
    issue(cbl_pkg::CMD_ACTIVATE, 4, 1'b0);
    issue(cbl_pkg::CMD_MODE_READ, 4, 1'b0);
    idle(20);
    issue(cbl_pkg::CMD_PRECHARGE, 3, 1'b0);
    issue(cbl_pkg::CMD_MODE_READ, 3, 1'b0);
    idle(20);
    issue(cbl_pkg::CMD_READ, 4, 1'b0);
    issue(cbl_pkg::CMD_PRECHARGE_ALL, 0, 1'b0);
    issue(cbl_pkg::CMD_BURST_STOP, 4, 1'b0);
    issue(cbl_pkg::CMD_MODE_WRITE, 0, 1'b0);
    issue(cbl_pkg::CMD_PRECHARGE_ALL, 0, 1'b0);
    idle(10);
    issue(cbl_pkg::CMD_MODE_WRITE, 0, 1'b0);
    issue(cbl_pkg::CMD_ACTIVATE, 1, 1'b0);
    idle(20);
    issue(cbl_pkg::CMD_REFRESH, 0, 1'b0);
    idle(30);
    issue(cbl_pkg::cbl_cmd_e'(4'hb), 0, 1'b0);
    idle(4);
    repeat (16) begin
      issue(rc[{$random(seed)} % 4], int'({$random(seed)} % 8), 1'b0);
      idle(16);
    end
    check(32'(viol), 32'h0);
    report_and_stop();
  end
endmodule
